// *** logic/bsi_pkg.sv ***
package bsi_pkg;

    // ****************************************************************
    // Register map: printed offsets are word indices, byte = 4 x index.
    // ****************************************************************
    localparam int          IDX_W        = 14;
    localparam logic [13:0] IDX_IDENTITY = 14'h1C00;
    localparam logic [13:0] IDX_CLK_CFG2 = 14'h1C1F;
    localparam logic [13:0] IDX_BOOT_SEL = 14'h1C34;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int ID_VARIANT_LSB = 28;
    localparam int ID_PART_LSB    = 12;
    localparam int ID_MFR_LSB     = 1;
    localparam int BOOT_LOW_LSB   = 5;
    localparam int BOOT_HIGH_LSB  = 9;
    localparam int CLK_STAT_BIT   = 2;

    // ****************************************************************
    // Reset values and timing counts.
    // ****************************************************************
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
    localparam logic [3:0]  LOW_RST       = 4'h0;
    localparam logic [1:0]  HIGH_RST      = 2'h0;
    localparam int          SYNC_STAGES   = 2;
    localparam int          HIGH_EDGE     = 10;
    localparam int          CNT_W         = 4;
    localparam logic [3:0]  HIGH_CNT_LAST =
        4'(HIGH_EDGE - SYNC_STAGES - 1);

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef enum logic [2:0] {
        FREQ_USB_12M,
        FREQ_EXT_11M2896,
        FREQ_EXT_12M_12M288,
        FREQ_EXT_16M8,
        FREQ_EXT_19M2
    } bsi_freq_t;

    typedef struct packed {
        logic       clk_src;
        logic [1:0] high;
        logic [3:0] low;
    } bsi_strap_t;

endpackage : bsi_pkg

// *** logic/bsi_boot_id_regs.sv ***
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
module bsi_boot_id_regs #(
    parameter logic [3:0]  VARIANT_CODE = 4'h1,     // Arbitrary value.
    parameter logic [15:0] PART_CODE    = 16'h1234, // Arbitrary value.
    parameter logic [10:0] MAKER_CODE   = 11'h055   // Arbitrary value.
) (
    input  wire logic                CLK,
    input  wire logic                RESET,
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic      [31:0]         HRDATA,
    output logic                     HREADYOUT,
    output logic                     HRESP,
    input  wire logic                BOOT_RESET_N,
    input  wire logic [5:0]          BOOT_STRAP_PINS,
    input  wire logic                CLOCK_SOURCE_PIN,
    output bsi_pkg::bsi_strap_t      BOOT_STATUS,
    output logic                     BOOT_CAPTURE_DONE,
    output bsi_pkg::bsi_freq_t       CLK_FREQ
);
    import bsi_pkg::*;

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    if (HIGH_EDGE <= SYNC_STAGES + 1 || HIGH_EDGE > 15) begin : g_chk
        $error("Upper capture edge cannot be served by the counter.");
    end

    // ****************************************************************
    // Reset pin synchroniser and release counter.
    // ****************************************************************
    logic             rst_meta_ff;
    logic             rst_sync_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             done_ff;
    logic             nxt_done;
    bsi_strap_t       strap_ff;
    bsi_strap_t       nxt_strap;
    bsi_freq_t        freq_ff;
    bsi_freq_t        nxt_freq;

    // The pin is asynchronous to CLK, so release is seen two edges late.
    // sync release
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= BOOT_RESET_N;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    wire cap_edge = rst_sync_ff && !done_ff && (cnt_ff == HIGH_CNT_LAST);

    assign nxt_cnt  = !rst_sync_ff ? '0 :
                      done_ff      ? cnt_ff : cnt_ff + 4'h1;
    assign nxt_done = rst_sync_ff && (done_ff || cap_edge);

    // ****************************************************************
    // Strap capture.
    // ****************************************************************
    // low bits latch
    // Low bits and clock pin follow the straps until release is seen,
    // so the last sample taken is the one at the release edge.
    assign nxt_strap.low     = !rst_sync_ff ? BOOT_STRAP_PINS[3:0] :
                               strap_ff.low;
    assign nxt_strap.clk_src = !rst_sync_ff ? CLOCK_SOURCE_PIN :
                               strap_ff.clk_src;
    assign nxt_strap.high    = cap_edge ? BOOT_STRAP_PINS[5:4] :
                               strap_ff.high;

    always_comb begin
        nxt_freq = FREQ_USB_12M;
        if (strap_ff.clk_src) begin
            unique case (strap_ff.high)
                2'b00: nxt_freq = FREQ_EXT_11M2896;
                2'b01: nxt_freq = FREQ_EXT_12M_12M288;
                2'b10: nxt_freq = FREQ_EXT_16M8;
                2'b11: nxt_freq = FREQ_EXT_19M2;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            cnt_ff   <= '0;
            done_ff  <= 1'b0;
            strap_ff <= '{clk_src: 1'b0, high: HIGH_RST, low: LOW_RST};
            freq_ff  <= FREQ_USB_12M;
        end else begin
            cnt_ff   <= nxt_cnt;
            done_ff  <= nxt_done;
            strap_ff <= nxt_strap;
            freq_ff  <= nxt_freq;
        end
    end

    assign BOOT_STATUS       = strap_ff;
    assign BOOT_CAPTURE_DONE = done_ff;
    assign CLK_FREQ          = freq_ff;

    // ****************************************************************
    // AHB-Lite slave: zero wait states, always OKAY.
    // ****************************************************************
    wire              bus_req   = HSEL && HREADY && HTRANS[1];
    wire [IDX_W-1:0]  bus_idx   = HADDR[IDX_W+1:2];
    wire              addr_hi0  = (HADDR[31:IDX_W+2] == '0);
    wire              hit_ident = addr_hi0 && (bus_idx == IDX_IDENTITY);
    wire              hit_clk   = addr_hi0 && (bus_idx == IDX_CLK_CFG2);
    wire              hit_boot  = addr_hi0 && (bus_idx == IDX_BOOT_SEL);

    wire [31:0] ident_word = {VARIANT_CODE, PART_CODE, MAKER_CODE, 1'b1};
    wire [31:0] boot_word  = {16'h0000, 5'h00, strap_ff.high,
                              strap_ff.low, 5'h00};
    wire [31:0] clk_word   = {29'h0000_0000, strap_ff.clk_src, 2'h0};

    // Unmapped addresses read as zero; writes reach no storage at all.
    wire [31:0] rd_mux = hit_ident ? ident_word :
                         hit_boot  ? boot_word  :
                         hit_clk   ? clk_word   : RD_ZERO;

    logic        rd_ff;
    logic        wr_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;

    assign nxt_hrdata = (bus_req && !HWRITE) ? rd_mux : RD_ZERO;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rd_ff     <= 1'b0;
            wr_ff     <= 1'b0;
            hrdata_ff <= RD_ZERO;
        end else begin
            rd_ff     <= bus_req && !HWRITE;
            wr_ff     <= bus_req && HWRITE;
            hrdata_ff <= nxt_hrdata;
        end
    end

    assign HRDATA    = hrdata_ff;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // ****************************************************************
    // Checker helper: edges seen with the pin high since it was low.
    // ****************************************************************
    // A ten-cycle repetition would be unrolled by the tools at great
    // cost, so the run of high samples is counted here instead. The
    // count saturates, which is harmless because only small values
    // are looked at.
    logic [CNT_W-1:0] hi_run_ff;
    logic [CNT_W-1:0] nxt_hi_run;

    assign nxt_hi_run = !BOOT_RESET_N      ? '0 :
                        (hi_run_ff == '1)  ? hi_run_ff :
                                             hi_run_ff + 4'h1;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            hi_run_ff <= '0;
        end else begin
            hi_run_ff <= nxt_hi_run;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // The pin is sampled high on the tenth edge since it was low.
    sequence s_pin_release;
        BOOT_RESET_N && hi_run_ff == 4'(HIGH_EDGE - 1);
    endsequence

    // One edge short of that, so no capture may be visible yet.
    sequence s_pin_early;
        BOOT_RESET_N && hi_run_ff == 4'(HIGH_EDGE - 2);
    endsequence

    a_ident_read: assert property (
        bus_req && !HWRITE && hit_ident |=>
            HRDATA[31:28] == VARIANT_CODE && HRDATA[27:12] == PART_CODE
            && HRDATA[11:1] == MAKER_CODE)
        else $error("Identity fields read back wrong.");

    a_ident_lsb: assert property (
        bus_req && !HWRITE && hit_ident |=> HRDATA[0])
        else $error("Identity bit 0 did not read one.");

    a_boot_reserved: assert property (
        bus_req && !HWRITE && hit_boot |=>
            HRDATA[31:11] == '0 && HRDATA[4:0] == '0
            && HRDATA[10:5] == $past({strap_ff.high, strap_ff.low}))
        else $error("Boot-select word read back wrong.");

    a_write_ignored: assert property (
        wr_ff && !cap_edge && rst_sync_ff |=> $stable(strap_ff))
        else $error("A write changed the captured straps.");

    a_high_capture: assert property (
        s_pin_release |=> done_ff
            && strap_ff.high == $past(BOOT_STRAP_PINS[5:4]))
        else $error("Upper bits not captured on tenth edge.");

    a_no_early_cap: assert property (
        s_pin_early |=> !done_ff)
        else $error("Upper bits captured before tenth edge.");

    a_high_hold: assert property (
        done_ff && BOOT_RESET_N |=> $stable(strap_ff.high))
        else $error("Captured upper bits changed while held.");

    a_low_capture: assert property (
        !rst_sync_ff |=> strap_ff.low == $past(BOOT_STRAP_PINS[3:0])
            && strap_ff.clk_src == $past(CLOCK_SOURCE_PIN))
        else $error("Lower bits not following straps before release.");

    a_clk_status: assert property (
        bus_req && !HWRITE && hit_clk |=>
            HRDATA == {29'h0, $past(strap_ff.clk_src), 2'h0})
        else $error("Clock status bit read back wrong.");

    a_freq_usb: assert property (
        !strap_ff.clk_src |=> CLK_FREQ == FREQ_USB_12M)
        else $error("USB oscillator frequency not indicated.");

    a_freq_ext: assert property (
        strap_ff.clk_src && strap_ff.high == 2'b01 |=>
            CLK_FREQ == FREQ_EXT_12M_12M288)
        else $error("External 12.288 MHz not indicated.");

    a_freq_ext_hi: assert property (
        strap_ff.clk_src && strap_ff.high == 2'b11 |=>
            CLK_FREQ == FREQ_EXT_19M2)
        else $error("External 19.2 MHz not indicated.");

    a_bus_okay: assert property (
        HREADYOUT && !HRESP)
        else $error("Slave stalled or answered an error.");

    a_freq_ext_lo: assert property (
        strap_ff.clk_src && strap_ff.high == 2'b00 |=>
            CLK_FREQ == FREQ_EXT_11M2896)
        else $error("External 11.2896 MHz not indicated.");

    a_freq_ext_mid: assert property (
        strap_ff.clk_src && strap_ff.high == 2'b10 |=>
            CLK_FREQ == FREQ_EXT_16M8)
        else $error("External 16.8 MHz not indicated.");

    a_cap_window: assert property (
        $rose(done_ff) |-> hi_run_ff >= 4'(HIGH_EDGE)
            && hi_run_ff <= 4'(HIGH_EDGE + SYNC_STAGES))
        else $error("Upper bits captured outside edges ten to twelve.");

    a_low_hold: assert property (
        rst_sync_ff |=> $stable(strap_ff.low)
            && $stable(strap_ff.clk_src))
        else $error("Lower bits or clock pin moved after release.");

    a_rdata_idle: assert property (
        !rd_ff |-> HRDATA == RD_ZERO)
        else $error("Read data showed without a read.");

endmodule : bsi_boot_id_regs

// *** test/bsi_strap_board.sv ***
`timescale 1ns/10ps
module bsi_strap_board (
    input  wire logic       CLK,
    input  wire logic       DONE_IN,
    output logic            RST_N,
    output logic [5:0]      PINS,
    output logic            CLK_SEL
);
    initial begin
        RST_N = 1'b0;
        PINS = 6'h00;
        CLK_SEL = 1'b0;
    end

    // The strap pins are shared with address lines, so they change once
    // the capture is over; a late sample would read the wrong level.
    // straps held through release
    task automatic strap_cycle(input logic [5:0] s, input logic c,
                               output int n);
        n = 0;
        @(posedge CLK);
        RST_N <= 1'b0;
        PINS <= s;
        CLK_SEL <= c;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
            #1;
        end while (DONE_IN !== 1'b1 && n < 16);
        repeat (2) @(posedge CLK);
        PINS <= ~s;
        CLK_SEL <= ~c;
    endtask : strap_cycle
endmodule : bsi_strap_board

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import bsi_pkg::*;
    localparam logic [3:0]  VC = 4'hA;     // Arbitrary value.
    localparam logic [15:0] PC = 16'h5C3E; // Arbitrary value.
    localparam logic [10:0] MC = 11'h2B1;  // Arbitrary value.
    logic        clk, rst, hsel, hwrite, hready, hresp, rst_n, csel, done;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [5:0]  pins;
    bsi_strap_t  status;
    bsi_freq_t   freq;
    int          err_total, cmp_count, seed, n;

    always #25 clk = ~clk;

    bsi_boot_id_regs #(.VARIANT_CODE(VC), .PART_CODE(PC), .MAKER_CODE(MC))
    DUT (
        .CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .BOOT_RESET_N(rst_n), .BOOT_STRAP_PINS(pins),
        .CLOCK_SOURCE_PIN(csel), .BOOT_STATUS(status),
        .BOOT_CAPTURE_DONE(done), .CLK_FREQ(freq)
    );
    bsi_strap_board board (.CLK(clk), .DONE_IN(done), .RST_N(rst_n),
                           .PINS(pins), .CLK_SEL(csel));

    // ****************************************************************
    // Tasks and expectations.
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic ahb(input logic [31:0] a, input logic w,
                       output logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        // Only the watchdog ends a wait; the slave sets the pace.
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= $random(seed);
        do @(posedge clk); while (hready !== 1'b1);
        d = hrdata;
        chk("response", 32'h0, 32'(hresp));
    endtask : ahb

    function automatic bsi_freq_t exp_freq(input logic c,
                                           input logic [1:0] h);
        if (!c) return FREQ_USB_12M;
        case (h)
            2'b00: return FREQ_EXT_11M2896;
            2'b01: return FREQ_EXT_12M_12M288;
            2'b10: return FREQ_EXT_16M8;
            default: return FREQ_EXT_19M2;
        endcase
    endfunction : exp_freq

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        err_total = 0;
        cmp_count = 0;
        seed = 32'he3ac;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        ahb(32'h7000, 1'b1, rd);
        ahb(32'h7000, 1'b0, rd);
        chk("identity", {VC, PC, MC, 1'b1}, rd);
        for (int i = 0; i < 14; i++) begin
            logic [5:0] s;
            logic       c;
            s = 6'($random(seed));
            c = 1'($random(seed));
            if (i < 8) begin
                s[5:4] = 2'(i);
                c = i[2];
            end
            board.strap_cycle(s, c, n);
            chk("capture edge", 32'h1, 32'(n >= 10 && n <= 12));
            repeat (2) @(posedge clk);
            chk("status", 32'({c, s}), 32'(status));
            chk("freq", 32'(exp_freq(c, s[5:4])), 32'(freq));
            ahb(32'h70D0, 1'b1, rd);
            ahb(32'h70D0, 1'b0, rd);
            chk("boot select", {21'h0, s, 5'h0}, rd);
            ahb(32'h707C, 1'b0, rd);
            chk("clock cfg", {29'h0, c, 2'h0}, rd);
        end
        ahb(32'h7004, 1'b0, rd);
        chk("unmapped", 32'h0, rd);
        close_out();
    end

    initial begin
        #200_000;
        err_total++;
        close_out();
    end
endmodule : tb_top
